// file: src/power_mode_ctrl.sv
// Purpose: Chip power states, wake-up sequencing and module clock gates
// Assumes: Host interface logic decodes its pins into regReq on clk
// Notes: Wake pins and PLL lock come from outside and are synchronised
`timescale 1ns/1ps

module power_mode_ctrl #(
  parameter int unsigned WAKE_MAX_CYC = `WAKE_MAX_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register access from host interface logic
  input power_mode_pkg::regReq_s regReq,
  output power_mode_pkg::regRsp_s regRsp,
  // Wake pins and PLL status, asynchronous
  input wire logic parWrPin,
  input wire logic serSelect_n,
  input wire logic serClkPin,
  input wire logic wakeEventPin,
  input wire logic pllLockPin,
  // Indicator sources and pad configuration
  input wire logic [`IND_COUNT-1:0] indLevel,
  input wire logic [`IND_COUNT-1:0] indOeIn,
  input wire logic [`IND_COUNT-1:0] indPushPull,
  input wire logic [`IND_COUNT-1:0] indActiveHigh,
  output power_mode_pkg::indPad_s indPad,
  // Clock run enables and status
  output power_mode_pkg::clkRun_s clkRun,
  output logic hostActive,
  output logic wakeLate
);
  import power_mode_pkg::*;

  // State of the block apart from the guarded bits
  typedef struct packed {
    pwr_e fsm;
    logic [2:0] mode;
    logic sleepReq;
    logic autoWake;
    logic indDis;
    logic ready;
    logic writeLock;
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic [31:0] wakeCnt;
    logic wakeLate;
    regRsp_s rsp;
    clkRun_s run;
    indPad_s pad;
    logic hostActive;
  } state_s;

  state_s st_r;
  state_s st_nxt;

  logic [`GUARD_COUNT-1:0] guardQ;
  logic [`GUARD_COUNT-1:0] guardWr;
  logic [`GUARD_COUNT-1:0] guardVal;
  logic hit;
  logic wrOk;
  logic parWr;
  logic serCycle;
  logic wakeEvt;
  logic pllLock;
  logic [2:0] wrMode;
  logic wrSleep;
  logic [31:0] readWord;

  // Synchronised pin levels, second stage only
  assign parWr = st_r.sync2[0];
  assign serCycle = ~st_r.sync2[1] & st_r.sync2[2];
  assign wakeEvt = st_r.sync2[3];
  assign pllLock = st_r.sync2[4];

  // Access decode and write acceptance
  assign hit = (regReq.addr == `PMC_OFFSET);
  assign wrOk = hit && regReq.wr && (st_r.fsm == PWR_AWAKE) &&
    (!st_r.writeLock || regReq.serial);
  assign wrMode = regReq.wdata[`PMC_MODE_HI:`PMC_MODE_LO];
  assign wrSleep = regReq.wdata[`PMC_SLEEP_BIT];

  // Guarded bit write values and strobes
  assign guardVal = {regReq.wdata[`PMC_TIMEUNIT_BIT],
    regReq.wdata[`PMC_STAMP2_BIT], regReq.wdata[`PMC_STAMP1_BIT],
    regReq.wdata[`PMC_STAMP0_BIT], regReq.wdata[`PMC_FABRIC_BIT],
    regReq.wdata[`PMC_HOSTMAC_BIT]};
  assign guardWr = {{2{regReq.byteEn[3]}}, {4{regReq.byteEn[2]}}} &
    {`GUARD_COUNT{wrOk}};

  // One guarded bit per clock domain, own counter each
  genvar gi;
  generate
    for (gi = 0; gi < `GUARD_COUNT; gi++) begin : g_guard
      guard_bit u_guard (
        .clk(clk),
        .reset_n(reset_n),
        .wrStrobe(guardWr[gi]),
        .wrValue(guardVal[gi]),
        .bitSet(guardQ[gi])
      );
    end
  endgenerate

  // Read word assembly, reserved bits zero
  always_comb begin
    readWord = 32'h0;
    readWord[`PMC_MODE_HI:`PMC_MODE_LO] = st_r.mode;
    readWord[`PMC_SLEEP_BIT] = st_r.sleepReq;
    readWord[`PMC_AUTOWAKE_BIT] = st_r.autoWake;
    readWord[`PMC_INDDIS_BIT] = st_r.indDis;
    readWord[`PMC_TIMEUNIT_BIT] = guardQ[5];
    readWord[`PMC_STAMP2_BIT] = guardQ[4];
    readWord[`PMC_STAMP1_BIT] = guardQ[3];
    readWord[`PMC_STAMP0_BIT] = guardQ[2];
    readWord[`PMC_FABRIC_BIT] = guardQ[1];
    readWord[`PMC_HOSTMAC_BIT] = guardQ[0];
    readWord[`PMC_READY_BIT] = st_r.ready;
  end

  // Next-state logic
  always_comb begin
    st_nxt = st_r;
    st_nxt.sync1 = {pllLockPin, wakeEventPin, serClkPin, serSelect_n,
      parWrPin};
    st_nxt.sync2 = st_r.sync1;

    // Reads answered in every state, whole word each time
    st_nxt.rsp.valid = hit && regReq.rd;
    st_nxt.rsp.data = readWord;
    if (hit && regReq.rd && st_r.fsm == PWR_AWAKE && !regReq.serial) begin
      st_nxt.writeLock = 1'b0;
    end

    // Register writes, top byte holds mode, sleep and enables
    if (wrOk && regReq.byteEn[3]) begin
      st_nxt.autoWake = regReq.wdata[`PMC_AUTOWAKE_BIT];
      st_nxt.indDis = regReq.wdata[`PMC_INDDIS_BIT];
      if (!wrSleep) begin
        st_nxt.mode = wrMode;
      end
      if (wrSleep && wrMode == st_r.mode) begin
        st_nxt.sleepReq = 1'b1;
      end
    end

    // Power state sequencing
    case (st_r.fsm)
      PWR_AWAKE: begin
        if (st_r.sleepReq) begin
          st_nxt.fsm = PWR_ASLEEP;
          st_nxt.ready = 1'b0;
          st_nxt.writeLock = 1'b1;
        end
      end
      PWR_ASLEEP: begin
        if (parWr || serCycle) begin
          st_nxt.fsm = PWR_WAKING;
        end else if (wakeEvt && st_r.autoWake &&
            st_r.mode != `PMC_MODE_D3) begin
          st_nxt.fsm = PWR_WAKING;
        end
        st_nxt.wakeCnt = 32'h0;
      end
      PWR_WAKING: begin
        if (st_r.wakeCnt < WAKE_MAX_CYC) begin
          st_nxt.wakeCnt = st_r.wakeCnt + 32'h1;
        end else begin
          st_nxt.wakeLate = 1'b1;
        end
        if (pllLock) begin
          st_nxt.fsm = PWR_AWAKE;
          st_nxt.ready = 1'b1;
          st_nxt.mode = `PMC_MODE_D0;
          st_nxt.sleepReq = 1'b0;
        end
      end
      default: begin
        st_nxt.fsm = PWR_AWAKE;
      end
    endcase
    if (st_r.fsm == PWR_AWAKE && st_r.sleepReq == 1'b0) begin
      st_nxt.wakeLate = st_r.wakeLate;
    end

    // Clock run enables, system clocks only while awake
    st_nxt.run.sysRun = (st_nxt.fsm == PWR_AWAKE);
    st_nxt.run.pllRun = !(st_nxt.fsm == PWR_ASLEEP &&
      (st_r.mode == `PMC_MODE_D2 || st_r.mode == `PMC_MODE_D3));
    st_nxt.run.xtalRun = !(st_nxt.fsm == PWR_ASLEEP &&
      st_r.mode == `PMC_MODE_D3);
    st_nxt.run.hostMacRun = st_nxt.run.sysRun & ~guardQ[0];
    st_nxt.run.fabricRun = st_nxt.run.sysRun & ~guardQ[1];
    st_nxt.run.stampRun = {3{st_nxt.run.sysRun}} & ~guardQ[4:2];
    st_nxt.run.timeUnitRun = st_nxt.run.sysRun & ~guardQ[5];
    st_nxt.hostActive = (st_nxt.fsm == PWR_AWAKE);

    // Indicator pads
    if (st_r.indDis) begin
      st_nxt.pad.oe = indPushPull;
      st_nxt.pad.out = ~indActiveHigh & indPushPull;
    end else begin
      st_nxt.pad.oe = indOeIn;
      st_nxt.pad.out = indLevel;
    end
  end

  // State register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
      st_r.fsm <= PWR_AWAKE;
      st_r.mode <= `PMC_MODE_RESET;
      st_r.ready <= `PMC_READY_RESET;
      st_r.run <= '1;
      st_r.hostActive <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign regRsp = st_r.rsp;
  assign clkRun = st_r.run;
  assign indPad = st_r.pad;
  assign hostActive = st_r.hostActive;
  assign wakeLate = st_r.wakeLate;

endmodule

// file: pkg/power_mode_params.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 100 MHz system clock
// Notes: Included by the package and the bench files
`ifndef POWER_MODE_PARAMS_SVH
`define POWER_MODE_PARAMS_SVH

// Register offset of the power management control register
`define PMC_OFFSET 12'h084
// Field positions
`define PMC_MODE_HI 31
`define PMC_MODE_LO 29
`define PMC_SLEEP_BIT 28
`define PMC_AUTOWAKE_BIT 27
`define PMC_INDDIS_BIT 26
`define PMC_TIMEUNIT_BIT 25
`define PMC_STAMP2_BIT 24
`define PMC_STAMP1_BIT 23
`define PMC_STAMP0_BIT 22
`define PMC_FABRIC_BIT 20
`define PMC_HOSTMAC_BIT 19
`define PMC_READY_BIT 0
// Power state codes
`define PMC_MODE_D0 3'h0
`define PMC_MODE_D1 3'h1
`define PMC_MODE_D2 3'h2
`define PMC_MODE_D3 3'h3
// Reset values
`define PMC_MODE_RESET 3'h0
`define PMC_READY_RESET 1'h1
// Timing: clock period and longest wake-up time
`define CLK_PERIOD_NS 10
`define WAKE_MAX_NS 2000000
`define WAKE_MAX_CYCLES (`WAKE_MAX_NS / `CLK_PERIOD_NS)
// Number of indicator outputs
`define IND_COUNT 4
// Number of guarded clock-disable bits
`define GUARD_COUNT 6

`endif

// file: pkg/power_mode_pkg.sv
// Purpose: Types shared by the power mode and clock gating block
// Assumes: power_mode_params.svh defines the widths
// Notes: Holds types only; numbers live in the header
`include "power_mode_params.svh"

package power_mode_pkg;

  // Power sequencing states
  typedef enum logic [1:0] {
    PWR_AWAKE,
    PWR_ASLEEP,
    PWR_WAKING
  } pwr_e;

  // Register access from the host interface logic
  typedef struct packed {
    logic [11:0] addr;
    logic wr;
    logic rd;
    logic [3:0] byteEn;
    logic [31:0] wdata;
    logic serial;
  } regReq_s;

  // Read answer
  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } regRsp_s;

  // Clock run enables toward the clock generator
  typedef struct packed {
    logic xtalRun;
    logic pllRun;
    logic sysRun;
    logic hostMacRun;
    logic fabricRun;
    logic timeUnitRun;
    logic [2:0] stampRun;
  } clkRun_s;

  // Indicator pad signals
  typedef struct packed {
    logic [`IND_COUNT-1:0] out;
    logic [`IND_COUNT-1:0] oe;
  } indPad_s;

  // State of one guarded clock-disable bit
  typedef struct packed {
    logic armed;
    logic value;
  } guard_s;

endpackage

// file: src/guard_bit.sv
// Purpose: One clock-disable bit that sets only on two writes of 1
// Assumes: Write strobe is a one-cycle pulse on the system clock
// Notes: A write of 0 clears both the bit and the pending count
`timescale 1ns/1ps

module guard_bit (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Write strobe and written value
  input wire logic wrStrobe,
  input wire logic wrValue,
  // Current bit value
  output logic bitSet
);
  import power_mode_pkg::*;

  guard_s state_r;
  guard_s state_nxt;

  // Consecutive write counter
  always_comb begin
    state_nxt = state_r;
    if (wrStrobe) begin
      if (wrValue) begin
        state_nxt.armed = 1'b1;
        if (state_r.armed) begin
          state_nxt.value = 1'b1;
        end
      end else begin
        state_nxt.armed = 1'b0;
        state_nxt.value = 1'b0;
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign bitSet = state_r.value;

endmodule

// file: bench/power_mode_ctrl_monitor.sv
// Purpose: Port checks on power_mode_ctrl
// Assumes: Bound to every power_mode_ctrl instance
// Notes: Guard checks expect writes two cycles apart
`timescale 1ns/1ps
`include "power_mode_params.svh"
module power_mode_ctrl_monitor #(
  parameter int unsigned WAKE_MAX_CYC = 50
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register bus
  input power_mode_pkg::regReq_s regReq,
  input power_mode_pkg::regRsp_s regRsp,
  // Status
  input wire logic pllLockPin,
  input power_mode_pkg::clkRun_s clkRun,
  input wire logic hostActive
);
  import power_mode_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Accepted write of 1 to one guarded bit
  sequence s_one(int b);
    hostActive && regReq.wr && regReq.addr == `PMC_OFFSET &&
      regReq.byteEn[b/8] && regReq.wdata[b];
  endsequence
  // Two such writes two cycles apart
  sequence s_set(int b);
    s_one(b) ##2 s_one(b);
  endsequence
  property p_readAns;
    regReq.rd && regReq.addr == `PMC_OFFSET |=> regRsp.valid;
  endproperty
  a_readAns: assert property (p_readAns) else $error("no read answer");
  property p_noAns;
    !(regReq.rd && regReq.addr == `PMC_OFFSET) |=> !regRsp.valid;
  endproperty
  a_noAns: assert property (p_noAns) else $error("stray answer");
  property p_sleepReady;
    regRsp.valid && regRsp.data[28] |-> !regRsp.data[0];
  endproperty
  a_sleepReady: assert property (p_sleepReady) else $error("ready asleep");
  property p_resv;
    regRsp.valid |-> regRsp.data[21] == 1'b0 && regRsp.data[18:1] == 18'h0;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved set");
  property p_sysOff;
    !hostActive |-> !clkRun.sysRun;
  endproperty
  a_sysOff: assert property (p_sysOff) else $error("clocks run asleep");
  property p_pllReady;
    $rose(hostActive) |-> $past(pllLockPin, 2);
  endproperty
  a_pllReady: assert property (p_pllReady) else $error("ready no lock");
  property p_timeUnit;
    s_set(25) |-> ##2 !clkRun.timeUnitRun;
  endproperty
  a_timeUnit: assert property (p_timeUnit) else $error("time unit on");
  property p_stamp0;
    s_set(22) |-> ##2 !clkRun.stampRun[0];
  endproperty
  a_stamp0: assert property (p_stamp0) else $error("stamp unit on");
  property p_fabric;
    s_set(20) |-> ##2 !clkRun.fabricRun;
  endproperty
  a_fabric: assert property (p_fabric) else $error("fabric on");
  property p_hostMac;
    s_set(19) |-> ##2 !clkRun.hostMacRun;
  endproperty
  a_hostMac: assert property (p_hostMac) else $error("host mac on");
endmodule
bind power_mode_ctrl power_mode_ctrl_monitor #(.WAKE_MAX_CYC(WAKE_MAX_CYC))
  u_mon (.clk(clk), .reset_n(reset_n), .regReq(regReq), .regRsp(regRsp),
  .pllLockPin(pllLockPin), .clkRun(clkRun), .hostActive(hostActive));

// file: bench/host_model.sv
// Purpose: Host processor on register bus and wake pins
// Assumes: Drives on the falling clock edge
// Notes: Idle write data shows the inverse of the last value
`timescale 1ns/1ps
`include "power_mode_params.svh"
module host_model (
  // Clock
  input wire logic clk,
  // Register bus
  output power_mode_pkg::regReq_s regReq,
  input power_mode_pkg::regRsp_s regRsp,
  // Wake pins
  output logic parWrPin,
  output logic serSelect_n,
  output logic serClkPin
);
  import power_mode_pkg::*;
  // Idle bus at time zero
  initial begin
    regReq = '0;
    parWrPin = 1'b0;
    serSelect_n = 1'b1;
    serClkPin = 1'b0;
  end
  // One write; callers send mode before sleep
  task automatic wr(input logic [31:0] d, input logic s);
    @(negedge clk);
    regReq.addr = `PMC_OFFSET;
    regReq.byteEn = 4'hF;
    regReq.serial = s;
    regReq.wdata = d;
    regReq.wr = 1'b1;
    @(negedge clk);
    regReq.wr = 1'b0;
    regReq.wdata = ~d;
  endtask
  // One parallel read with bounded wait
  task automatic rd(output logic [31:0] d);
    int i;
    @(negedge clk);
    regReq.addr = `PMC_OFFSET;
    regReq.serial = 1'b0;
    regReq.rd = 1'b1;
    @(negedge clk);
    regReq.rd = 1'b0;
    for (i = 0; i < 4 && regRsp.valid !== 1'b1; i++) begin
      @(negedge clk);
    end
    d = regRsp.data;
  endtask
  // Waking parallel write strobe
  task automatic parWake();
    @(negedge clk);
    parWrPin = 1'b1;
    repeat (2) @(negedge clk);
    parWrPin = 1'b0;
  endtask
  // Serial frame, select low and clock high
  task automatic serWake();
    @(negedge clk);
    serSelect_n = 1'b0;
    serClkPin = 1'b1;
    repeat (2) @(negedge clk);
    serClkPin = 1'b0;
    serSelect_n = 1'b1;
  endtask
endmodule

// file: bench/tb_power_mode_ctrl.sv
// Purpose: Self-checking bench for power_mode_ctrl
// Assumes: Wake limit shortened to 50 cycles
// Notes: Host model makes all register traffic and the parallel and serial wake pins
`timescale 1ns/1ps
`include "power_mode_params.svh"
module tb_power_mode_ctrl;
  import power_mode_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic pllLockPin = 1'b1;
  logic wakeEventPin = 1'b0;
  regReq_s regReq;
  regRsp_s regRsp;
  indPad_s indPad;
  clkRun_s clkRun;
  logic parWrPin, serSelect_n, serClkPin, hostActive, wakeLate;
  int mismatches = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [31:0] d;
  always #5 clk = ~clk;
  // Block under test, indicator inputs tied
  power_mode_ctrl #(.WAKE_MAX_CYC(50)) dut (.clk(clk), .reset_n(reset_n),
    .regReq(regReq), .regRsp(regRsp), .parWrPin(parWrPin),
    .serSelect_n(serSelect_n), .serClkPin(serClkPin),
    .wakeEventPin(wakeEventPin), .pllLockPin(pllLockPin),
    .indLevel(4'hF), .indOeIn(4'hF), .indPushPull(4'h3),
    .indActiveHigh(4'h5), .indPad(indPad), .clkRun(clkRun),
    .hostActive(hostActive), .wakeLate(wakeLate));
  host_model u_host (.clk(clk), .regReq(regReq), .regRsp(regRsp),
    .parWrPin(parWrPin), .serSelect_n(serSelect_n), .serClkPin(serClkPin));
  // Compare and count
  task automatic chk(input logic [31:0] g, e, input string m);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Bounded wait for the host side to come back
  task automatic waitAwake();
    int i;
    for (i = 0; i < 50 && hostActive !== 1'b1; i++) begin
      @(negedge clk);
    end
    chk(32'(hostActive), 32'h1, "not awake");
  endtask
  task automatic t_reset();
    u_host.rd(d);
    chk(d, 32'h1, "reset word");
    chk(32'(clkRun), 32'h1FF, "reset clocks");
  endtask
  // Each guard: 1,0,1 stays clear, then 1,1 sets
  task automatic t_guard();
    int b [6] = '{19, 20, 25, 24, 23, 22};
    int i;
    for (i = 0; i < 6; i++) begin
      u_host.wr(32'h1 << b[i], 1'b0);
      u_host.wr(32'h0, 1'b0);
      u_host.wr(32'h1 << b[i], 1'b0);
      u_host.rd(d);
      chk(d, 32'h1, "guard early");
      u_host.wr(32'h0, 1'b0);
      u_host.wr(32'h1 << b[i], 1'b0);
      u_host.wr(32'h1 << b[i], 1'b0);
      u_host.rd(d);
      chk(d, (32'h1 << b[i]) | 32'h1, "guard");
      chk(32'(clkRun), 32'h1FF ^ (32'h20 >> i), "gate");
      u_host.wr(32'h0, 1'b0);
    end
  endtask
  // D1 sleep, slow PLL, parallel wake and write lockout
  task automatic t_sleep();
    u_host.wr(32'h2000_0000, 1'b0);
    u_host.wr(32'h5000_0000, 1'b0);
    u_host.rd(d);
    chk(d, 32'h2000_0001, "mixed write");
    pllLockPin = 1'b0;
    u_host.wr(32'h3000_0000, 1'b0);
    u_host.wr(32'h0400_0000, 1'b0);
    u_host.rd(d);
    chk(d, 32'h3000_0000, "asleep word");
    chk(32'(clkRun), 32'h180, "D1 clocks");
    u_host.parWake();
    repeat (20) @(negedge clk);
    chk(32'(hostActive), 32'h0, "ready early");
    pllLockPin = 1'b1;
    waitAwake();
    u_host.wr(32'h0400_0000, 1'b0);
    u_host.rd(d);
    chk(d, 32'h1, "woken word");
    chk(32'(indPad), 32'hFF, "pads on");
    u_host.wr(32'h0400_0000, 1'b0);
    u_host.rd(d);
    chk(d, 32'h0400_0001, "late write");
    chk(32'(indPad), 32'h23, "pads");
    u_host.wr(32'h0, 1'b0);
  endtask
  // Auto wake off, serial wake, auto wake, D3
  task automatic t_auto();
    u_host.wr(32'h2000_0000, 1'b0);
    u_host.wr(32'h3000_0000, 1'b0);
    wakeEventPin = 1'b1;
    repeat (10) @(negedge clk);
    chk(32'(hostActive), 32'h0, "auto off woke");
    wakeEventPin = 1'b0;
    u_host.serWake();
    waitAwake();
    u_host.wr(32'h2800_0000, 1'b1);
    u_host.wr(32'h3800_0000, 1'b1);
    u_host.rd(d);
    chk(d, 32'h3800_0000, "serial write");
    wakeEventPin = 1'b1;
    waitAwake();
    wakeEventPin = 1'b0;
    chk(32'(wakeLate), 32'h0, "late");
    u_host.wr(32'h6800_0000, 1'b1);
    u_host.wr(32'h7800_0000, 1'b1);
    wakeEventPin = 1'b1;
    repeat (10) @(negedge clk);
    chk(32'(hostActive), 32'h0, "D3 auto");
    chk(32'(clkRun), 32'h0, "D3 clocks");
    wakeEventPin = 1'b0;
    u_host.parWake();
    waitAwake();
    u_host.rd(d);
    chk(d, 32'h0800_0001, "D3 woken");
    // Slow PLL past the wake limit sets the late flag
    u_host.wr(32'h2800_0000, 1'b0);
    u_host.wr(32'h3800_0000, 1'b0);
    pllLockPin = 1'b0;
    u_host.parWake();
    repeat (60) @(negedge clk);
    pllLockPin = 1'b1;
    waitAwake();
    chk(32'(wakeLate), 32'h1, "late flag");
  endtask
  // Main sequence
  initial begin
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    t_reset();
    t_guard();
    t_sleep();
    t_auto();
    final_report();
  end
  // Cycle ceiling against a hang
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      mismatches++;
      final_report();
    end
  end
endmodule
